// File: sac_pkg.sv
// Package with constants, register map and types of the converter control block
`default_nettype none

package sac_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte offsets on the plain register port)
  localparam logic [7:0] SAC_OFS_STATUS = 8'h00;  // Status/control register
  localparam logic [7:0] SAC_OFS_RESULT = 8'h01;  // Result register
  localparam logic [7:0] SAC_OFS_CLOCK  = 8'h02;  // Clock control register

  ////////////////////////////////////////////////////////////////////////////////
  // Status/control field positions
  localparam int SAC_FLAG_BIT  = 7;  // Conversion done flag / interrupt route select
  localparam int SAC_IRQEN_BIT = 6;  // Conversion interrupt enable
  localparam int SAC_CONT_BIT  = 5;  // Continuous conversion
  localparam int SAC_CH_MSB    = 4;  // Channel select, top bit
  localparam int SAC_CH_LSB    = 0;  // Channel select, bottom bit

  // Clock control field positions
  localparam int SAC_DIV_MSB     = 7;  // Divider field, top bit
  localparam int SAC_DIV_LSB     = 5;  // Divider field, bottom bit
  localparam int SAC_CLKSEL_BIT  = 4;  // Input clock select

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset, and the first trial value
  localparam logic [4:0] SAC_CH_RST     = 5'h1F;  // Channel select starts powered off
  localparam logic [2:0] SAC_DIV_RST    = 3'h0;   // Divide by one
  localparam logic [7:0] SAC_RESULT_RST = 8'h00;  // Result register
  localparam logic [7:0] SAC_SAR_MSB    = 8'h80;  // First trial value

  ////////////////////////////////////////////////////////////////////////////////
  // Channel codes
  localparam logic [4:0] SAC_CH_LAST_PIN  = 5'h07;  // Highest external input
  localparam logic [4:0] SAC_CH_REF_HIGH  = 5'h1D;  // Internal high reference
  localparam logic [4:0] SAC_CH_GROUND    = 5'h1E;  // Internal analog ground
  localparam logic [4:0] SAC_CH_POWER_OFF = 5'h1F;  // Converter powered down

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counts, in converter clock ticks
  localparam logic [3:0] SAC_SAMPLE_TICKS = 4'h8;  // Sampling phase length
  localparam logic [2:0] SAC_LAST_BIT     = 3'h7;  // Index of first trial bit

  // Prescaler terminal counts (ratio minus one)
  localparam logic [3:0] SAC_TERM_DIV1  = 4'h0;
  localparam logic [3:0] SAC_TERM_DIV2  = 4'h1;
  localparam logic [3:0] SAC_TERM_DIV4  = 4'h3;
  localparam logic [3:0] SAC_TERM_DIV8  = 4'h7;
  localparam logic [3:0] SAC_TERM_DIV16 = 4'hF;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } sac_bus_req_t;

  typedef struct packed {
    logic [7:0] pin_sel;       // One-hot external input select
    logic       ref_high_sel;  // Route high reference
    logic       ground_sel;    // Route analog ground
    logic       power_down;    // Analog section off
  } sac_mux_t;

  typedef enum logic [2:0] {
    SAC_IDLE   = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_TRIAL  = 3'b100
  } sac_state_t;

endpackage : sac_pkg

`default_nettype wire

// File: sac_prescaler.sv
// Prescaler that turns source ticks into converter clock ticks
`default_nettype none

module sac_prescaler (
  input  wire logic       ref_clk,   // Bus clock
  input  wire logic       rstn,      // Synchronous reset, active low
  input  wire logic       src_tick,  // One pulse per selected source clock
  input  wire logic [2:0] div_code,  // Divider field
  output logic            adc_tick   // One pulse per converter clock
);

  logic [3:0] count_reg;  // Source ticks seen in this period
  logic [3:0] term;       // Terminal count for the ratio

  ////////////////////////////////////////////////////////////////////////////////
  // Ratio decode; top bit set means divide by sixteen
  always_comb begin
    case (div_code)
      3'h0:    term = sac_pkg::SAC_TERM_DIV1;
      3'h1:    term = sac_pkg::SAC_TERM_DIV2;
      3'h2:    term = sac_pkg::SAC_TERM_DIV4;
      3'h3:    term = sac_pkg::SAC_TERM_DIV8;
      default: term = sac_pkg::SAC_TERM_DIV16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter; >= so a smaller ratio written mid-period wraps at once
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_reg <= 4'h0;
      adc_tick  <= 1'b0;
    end else if (src_tick) begin
      if (count_reg >= term) begin
        count_reg <= 4'h0;
        adc_tick  <= 1'b1;
      end else begin
        count_reg <= count_reg + 4'h1;
        adc_tick  <= 1'b0;
      end
    end else begin
      adc_tick <= 1'b0;
    end
  end

endmodule : sac_prescaler

`default_nettype wire

// File: sac_control.sv
// Top of the successive-approximation converter control block
//
// Our own choices: strobed register access and the address map.
`default_nettype none

module sac_control (
  input  wire logic                 ref_clk,         // Bus clock, 100 MHz
  input  wire logic                 rstn,            // Synchronous reset, active low
  input  wire sac_pkg::sac_bus_req_t bus_req,        // Register port request
  output logic [7:0]                rd_data,         // Read data, cycle after read strobe
  output logic                      irq,             // Conversion interrupt request
  input  wire logic                 crystal_clock,   // Crystal clock pin
  input  wire logic                 comparator_high, // Analog input at or above trial
  output logic [7:0]                dac_code,        // Trial code to the comparator DAC
  output logic                      sample_enable,   // Sampling switch closed
  output sac_pkg::sac_mux_t         mux_ctrl,        // Analog multiplexer controls
  input  wire logic [7:0]           port_read_in,    // Port read values from port logic
  output logic [7:0]                port_read_out,   // Port read values after masking
  output logic [7:0]                port_force_input // Pins taken over by the converter
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       irqen_reg;        // Conversion interrupt enable
  logic       cont_reg;         // Continuous conversion
  logic [4:0] channel_reg;      // Channel select
  logic [2:0] div_reg;          // Clock divider field
  logic       clksel_reg;       // Input clock select, 1 = bus clock
  logic [7:0] result_reg;       // Last conversion result
  logic       flag_reg;         // Done flag, or route select while interrupts on
  logic       irq_pending_reg;  // Pending interrupt request
  logic       first_done_reg;   // A completion seen since the last control write
  logic [7:0] sar_reg;          // Approximation register
  logic [2:0] bit_reg;          // Bit under trial
  logic [3:0] tick_cnt_reg;     // Ticks spent sampling
  logic [7:0] rd_data_reg;      // Registered read data
  logic [7:0] pin_sel_reg;      // One-hot external input select
  logic       ref_high_reg;     // High reference routed
  logic       ground_reg;       // Ground routed
  logic       power_down_reg;   // Analog section off
  logic [7:0] port_read_reg;    // Masked port read values
  logic [2:0] xtal_sync_reg;    // Crystal pin synchroniser chain
  logic       xtal_level_reg;   // Accepted crystal level
  logic       xtal_rise;        // Accepted rising edge of the crystal clock
  logic       src_tick;         // Selected source tick
  logic       adc_tick;         // Converter clock tick
  logic       wr_status;        // Write to status/control
  logic       wr_clock;         // Write to clock control
  logic       rd_result;        // Read of result
  logic       start_req;        // Write that starts a conversion
  logic       conv_done;        // Last trial decided this cycle
  logic       set_flag;         // Done flag should set now
  logic [7:0] final_code;       // Result with the last bit decided
  logic [7:0] status_value;     // Status/control read value
  logic [7:0] clock_value;      // Clock control read value
  sac_pkg::sac_state_t state_reg;  // Conversion sequencer state

  ////////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign wr_status = bus_req.wr && (bus_req.addr == sac_pkg::SAC_OFS_STATUS);
  assign wr_clock  = bus_req.wr && (bus_req.addr == sac_pkg::SAC_OFS_CLOCK);
  assign rd_result = bus_req.rd && (bus_req.addr == sac_pkg::SAC_OFS_RESULT);

  // A write with the power-off code never starts anything
  assign start_req = wr_status &&
                     (bus_req.wdata[sac_pkg::SAC_CH_MSB:sac_pkg::SAC_CH_LSB]
                      != sac_pkg::SAC_CH_POWER_OFF);

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields of the status/control register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irqen_reg   <= 1'b0;
      cont_reg    <= 1'b0;
      channel_reg <= sac_pkg::SAC_CH_RST;
    end else if (wr_status) begin
      irqen_reg   <= bus_req.wdata[sac_pkg::SAC_IRQEN_BIT];
      cont_reg    <= bus_req.wdata[sac_pkg::SAC_CONT_BIT];
      channel_reg <= bus_req.wdata[sac_pkg::SAC_CH_MSB:sac_pkg::SAC_CH_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock control register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_reg    <= sac_pkg::SAC_DIV_RST;
      clksel_reg <= 1'b0;
    end else if (wr_clock) begin
      div_reg    <= bus_req.wdata[sac_pkg::SAC_DIV_MSB:sac_pkg::SAC_DIV_LSB];
      clksel_reg <= bus_req.wdata[sac_pkg::SAC_CLKSEL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crystal pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      xtal_sync_reg  <= 3'h0;
      xtal_level_reg <= 1'b0;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_clock};
      if (xtal_sync_reg[1] == xtal_sync_reg[2]) begin
        xtal_level_reg <= xtal_sync_reg[2];
      end
    end
  end

  // Crystal must be well below a quarter of the bus clock to be seen cleanly
  assign xtal_rise = (xtal_sync_reg[1] == xtal_sync_reg[2]) && xtal_sync_reg[2] &&
                     !xtal_level_reg;

  // Source choice: bus clock ticks every cycle
  assign src_tick = clksel_reg ? 1'b1 : xtal_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running prescaler; its phase against the start write gives 15 to 16 tick periods
  sac_prescaler u_prescaler (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .src_tick (src_tick),
    .div_code (div_reg),
    .adc_tick (adc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Completion of the last trial bit
  assign conv_done  = (state_reg == sac_pkg::SAC_TRIAL) && adc_tick && (bit_reg == 3'h0);
  assign final_code = comparator_high ? sar_reg : (sar_reg & 8'hFE);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: eight sampling ticks, then eight trial ticks
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg    <= sac_pkg::SAC_IDLE;
      sar_reg      <= 8'h00;
      bit_reg      <= 3'h0;
      tick_cnt_reg <= 4'h0;
    end else if (wr_status) begin
      // Any control write aborts; it restarts the conversion unless it writes the power-off code
      tick_cnt_reg <= 4'h0;
      bit_reg      <= sac_pkg::SAC_LAST_BIT;
      sar_reg      <= 8'h00;
      if (start_req) begin
        state_reg <= sac_pkg::SAC_SAMPLE;
      end else begin
        state_reg <= sac_pkg::SAC_IDLE;
      end
    end else begin
      case (state_reg)
        sac_pkg::SAC_IDLE: begin
          // Waits for a control write
          state_reg <= sac_pkg::SAC_IDLE;
        end
        sac_pkg::SAC_SAMPLE: begin
          if (adc_tick) begin
            if (tick_cnt_reg == sac_pkg::SAC_SAMPLE_TICKS - 4'h1) begin
              state_reg <= sac_pkg::SAC_TRIAL;
              bit_reg   <= sac_pkg::SAC_LAST_BIT;
              sar_reg   <= sac_pkg::SAC_SAR_MSB;
            end else begin
              tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
          end
        end
        sac_pkg::SAC_TRIAL: begin
          if (adc_tick) begin
            if (bit_reg == 3'h0) begin
              tick_cnt_reg <= 4'h0;
              sar_reg      <= 8'h00;
              bit_reg      <= sac_pkg::SAC_LAST_BIT;
              if (cont_reg) begin
                state_reg <= sac_pkg::SAC_SAMPLE;
              end else begin
                state_reg <= sac_pkg::SAC_IDLE;
              end
            end else begin
              // Keep the bit if input is at or above, then try the next one
              sar_reg[bit_reg]        <= comparator_high;
              sar_reg[bit_reg - 3'h1] <= 1'b1;
              bit_reg                 <= bit_reg - 3'h1;
            end
          end
        end
        default: begin
          state_reg <= sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result register, overwritten whether read or not
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      result_reg <= sac_pkg::SAC_RESULT_RST;
    end else if (conv_done) begin
      result_reg <= final_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Done flag; in continuous mode only the first completion after a write sets it
  assign set_flag = conv_done && !irqen_reg && (!cont_reg || !first_done_reg);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      first_done_reg <= 1'b0;
    end else if (conv_done) begin
      first_done_reg <= 1'b1;
    end else if (wr_status) begin
      first_done_reg <= 1'b0;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flag_reg <= 1'b0;
    end else if (set_flag) begin
      flag_reg <= 1'b1;
    end else if (wr_status) begin
      // Writable route select only while interrupts are enabled
      flag_reg <= bus_req.wdata[sac_pkg::SAC_IRQEN_BIT] &&
                  bus_req.wdata[sac_pkg::SAC_FLAG_BIT];
    end else if (rd_result && !irqen_reg) begin
      flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request; a set route bit masks it since no other server exists
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_pending_reg <= 1'b0;
    end else if (conv_done && irqen_reg) begin
      irq_pending_reg <= 1'b1;
    end else if (wr_status || rd_result) begin
      irq_pending_reg <= 1'b0;
    end
  end

  assign irq = irq_pending_reg && !flag_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Multiplexer decode; reserved codes route nothing and give an undefined result
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          pin_sel_reg[gi] <= 1'b0;
        end else begin
          pin_sel_reg[gi] <= (channel_reg == 5'(gi));
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ref_high_reg   <= 1'b0;
      ground_reg     <= 1'b0;
      power_down_reg <= 1'b1;
    end else begin
      ref_high_reg   <= (channel_reg == sac_pkg::SAC_CH_REF_HIGH);
      ground_reg     <= (channel_reg == sac_pkg::SAC_CH_GROUND);
      power_down_reg <= (channel_reg == sac_pkg::SAC_CH_POWER_OFF);
    end
  end

  assign mux_ctrl.pin_sel      = pin_sel_reg;
  assign mux_ctrl.ref_high_sel = ref_high_reg;
  assign mux_ctrl.ground_sel   = ground_reg;
  assign mux_ctrl.power_down   = power_down_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Port takeover: selected pin is an input and reads back as zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      port_read_reg <= 8'h00;
    end else begin
      port_read_reg <= port_read_in & ~pin_sel_reg;
    end
  end

  assign port_force_input = pin_sel_reg;
  assign port_read_out    = port_read_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Analog drive
  assign dac_code      = sar_reg;
  assign sample_enable = (state_reg == sac_pkg::SAC_SAMPLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads give zero
  assign status_value = {flag_reg, irqen_reg, cont_reg, channel_reg};
  assign clock_value  = {div_reg, clksel_reg, 4'h0};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_data_reg <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        sac_pkg::SAC_OFS_STATUS: rd_data_reg <= status_value;
        sac_pkg::SAC_OFS_RESULT: rd_data_reg <= result_reg;
        sac_pkg::SAC_OFS_CLOCK:  rd_data_reg <= clock_value;
        default:                 rd_data_reg <= 8'h00;
      endcase
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign rd_data = rd_data_reg;

endmodule : sac_control

`default_nettype wire

// File: sac_props.sv
// Port checker of the converter control block
`default_nettype none
module sac_props (
  input wire logic                  ref_clk,          // Clock
  input wire logic                  rstn,             // Reset, active low
  input wire sac_pkg::sac_bus_req_t bus_req,          // Register request
  input wire logic [7:0]            rd_data,          // Read data
  input wire logic                  irq,              // Interrupt request
  input wire logic                  crystal_clock,    // Crystal clock
  input wire logic                  comparator_high,  // Comparator
  input wire logic [7:0]            dac_code,         // Trial code
  input wire logic                  sample_enable,    // Sampling
  input wire sac_pkg::sac_mux_t     mux_ctrl,         // Routes
  input wire logic [7:0]            port_read_in,     // Port values
  input wire logic [7:0]            port_read_out,    // Masked port values
  input wire logic [7:0]            port_force_input  // Forced pins
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Sampling ends on its own, not through an abort write
  sequence s_trial_entry;
    !$past(bus_req.wr) ##0 $fell(sample_enable);
  endsequence
  // Software reads the result while a request is pending
  sequence s_result_read;
    bus_req.rd && bus_req.addr == sac_pkg::SAC_OFS_RESULT && irq;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_RESET_QUIET: assert property ($rose(rstn) |-> !irq && !sample_enable && mux_ctrl.power_down)
    else $error("Outputs not quiet after reset");
  AST_READ_DROPS_IRQ: assert property (s_result_read |=> !irq)
    else $error("Result read left request up");
  AST_WRITE_DROPS_IRQ: assert property (bus_req.wr && bus_req.addr == sac_pkg::SAC_OFS_STATUS && irq
    |=> !irq)
    else $error("Control write left request up");
  AST_IRQ_AT_LAST_TRIAL: assert property ($rose(irq) |-> $past(dac_code[0]))
    else $error("Request rose outside the last trial");
  AST_TRIAL_START: assert property (s_trial_entry |-> dac_code == sac_pkg::SAC_SAR_MSB)
    else $error("Trial did not start at top bit");
  AST_FORCE_MATCH: assert property (port_force_input == mux_ctrl.pin_sel)
    else $error("Forced pins differ from routed pin");
  AST_PIN_READS_ZERO: assert property ($stable(port_force_input)
    |-> (port_read_out & port_force_input) == 8'h00)
    else $error("Routed pin did not read zero");
  AST_ONE_ROUTE: assert property ($onehot0({mux_ctrl.pin_sel, mux_ctrl.ref_high_sel,
    mux_ctrl.ground_sel, mux_ctrl.power_down}))
    else $error("More than one route active");
  AST_POWER_QUIET: assert property ($rose(mux_ctrl.power_down) |-> !sample_enable)
    else $error("Sampling while powered down");
  AST_READ_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("Read data outside answer cycle");
endmodule : sac_props

bind sac_control sac_props u_props (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
  .rd_data(rd_data), .irq(irq), .crystal_clock(crystal_clock), .comparator_high(comparator_high),
  .dac_code(dac_code), .sample_enable(sample_enable), .mux_ctrl(mux_ctrl),
  .port_read_in(port_read_in), .port_read_out(port_read_out), .port_force_input(port_force_input));
`default_nettype wire

// File: sac_analog_model.sv
// Behavioural analog front end: multiplexer, sample-hold and comparator
`default_nettype none
module sac_analog_model (
  input  wire logic              ref_clk,         // Clock
  input  wire logic [7:0][7:0]   pin_level,       // Level on each shared pin
  input  wire logic [7:0]        dac_code,        // Trial code
  input  wire logic              sample_enable,   // Sampling switch
  input  wire sac_pkg::sac_mux_t mux_ctrl,        // Route controls
  output logic                   comparator_high  // Input at or above trial
);
  logic [7:0] held  = 8'h00;  // Sampled level
  logic       valid = 1'b0;   // A real node is routed
  logic       noise = 1'b0;   // Toggles, so no stale answer looks valid
  // Hold the routed level while the switch is closed
  always_ff @(posedge ref_clk) begin
    noise <= ~noise;
    if (sample_enable) begin
      valid <= (|mux_ctrl.pin_sel) | mux_ctrl.ref_high_sel | mux_ctrl.ground_sel;
      held  <= mux_ctrl.ref_high_sel ? 8'hFF : 8'h00;
      for (int i = 0; i < 8; i++) begin
        if (mux_ctrl.pin_sel[i]) held <= pin_level[i];
      end
    end
  end
  // Unrouted or powered-off input gives no stable answer
  assign comparator_high = (valid && !mux_ctrl.power_down) ? (held >= dac_code) : noise;
endmodule : sac_analog_model
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the converter control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk = 1'b0;        // Bus clock
  logic                  rstn = 1'b0;           // Reset, active low
  sac_pkg::sac_bus_req_t bus_req = '0;          // Register port
  logic                  crystal_clock = 1'b0;  // Crystal clock
  logic [7:0]            port_read_in = 8'h00;  // Port values
  logic [7:0]            rd_data, dac_code, port_read_out, port_force_input;  // Outputs
  logic                  irq, comparator_high, sample_enable;  // Outputs
  sac_pkg::sac_mux_t     mux_ctrl;              // Routes
  logic [7:0][7:0]       pin_level = '0;        // Analog levels
  logic [8:0]            exp_q[$];              // Check flag and expected read data
  logic                  rd_q = 1'b0;           // Read taken last edge
  logic [31:0]           seed = 32'h0000000F;   // Xorshift state
  int                    error_cnt = 0;         // Mismatches
  int                    n_tests = 0;           // Comparisons
  int                    cyc = 0;               // Timeout counter
  // Clocks; the crystal runs well under a quarter of the bus rate
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    forever #26 crystal_clock = ~crystal_clock;
  end
  sac_control u_dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
    .irq(irq), .crystal_clock(crystal_clock), .comparator_high(comparator_high),
    .dac_code(dac_code), .sample_enable(sample_enable), .mux_ctrl(mux_ctrl),
    .port_read_in(port_read_in), .port_read_out(port_read_out),
    .port_force_input(port_force_input));
  sac_analog_model u_model (.ref_clk(ref_clk), .pin_level(pin_level), .dac_code(dac_code),
    .sample_enable(sample_enable), .mux_ctrl(mux_ctrl), .comparator_high(comparator_high));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask : check
  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // One access, then an idle cycle so strobes never get two drivers in one step
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    bus(a, 8'h00, 1'b0);
  endtask : rd
  // Start a conversion with interrupts on; count cycles until the request
  task automatic conv(input logic [7:0] ctl, output int n);
    seed = xs(seed);
    port_read_in <= seed[15:8];
    bus(sac_pkg::SAC_OFS_STATUS, ctl, 1'b1);
    n = 2;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : conv
  ////////////////////////////////////////////////////////////////////////////////
  // Compare each read answer with the oldest note
  always @(posedge ref_clk) begin
    logic [8:0] e;
    if (rd_q) begin
      e = exp_q.pop_front();
      if (e[8]) check("rd_data", rd_data, e[7:0]);
    end
    rd_q <= bus_req.rd;
  end
  // Hang guard, far above the planned run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, r;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 8'h1F);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pin_level[i] = seed[7:0];
    end
    // Crystal source after reset, divide by one; first run after power-up only settles
    conv(8'h43, n);
    conv(8'h43, n);
    check("xtal_time", 8'(n >= 75 && n <= 95), 8'h01);
    rd(8'h01, pin_level[3]);
    check("irq_read", {7'h00, irq}, 8'h00);
    // Bus source, every divider code on its own channel
    for (int i = 0; i < 8; i++) begin
      r = (i < 4) ? (1 << i) : 16;
      bus(sac_pkg::SAC_OFS_CLOCK, {i[2:0], 5'h10}, 1'b1);
      conv(8'h40 | 8'(i), n);
      check("div_time", 8'(n >= 15 * r && n <= 17 * r + 4), 8'h01);
      check("forced", port_force_input, 8'h01 << i);
      check("port_mask", port_read_out, port_read_in & ~(8'h01 << i));
      rd(8'h01, pin_level[i]);
    end
    // High reference, a masked request, a reserved code that still finishes, then ground
    bus(sac_pkg::SAC_OFS_CLOCK, 8'h10, 1'b1);
    conv(8'h5D, n);
    rd(8'h01, 8'hFF);
    conv(8'hC1, n);
    check("irq_masked", 8'(n == 2000), 8'h01);
    conv(8'h4A, n);
    check("reserved_time", 8'(n <= 21), 8'h01);
    conv(8'h5E, n);
    rd(8'h01, 8'h00);
    conv(8'h5E, n);
    bus(8'h00, 8'h1F, 1'b1);
    check("irq_write", {7'h00, irq}, 8'h00);
    repeat (40) begin
      @(posedge ref_clk);
      check("powered_off", {7'h00, sample_enable}, 8'h00);
    end
    // Flag mode, single conversion; the first run after power-up only settles
    bus(8'h00, 8'h02, 1'b1);
    repeat (30) @(posedge ref_clk);
    bus(8'h00, 8'h02, 1'b1);
    repeat (30) @(posedge ref_clk);
    rd(8'h00, 8'h82);
    check("single_idle", {6'h00, irq, sample_enable}, 8'h00);
    rd(8'h01, pin_level[2]);
    rd(8'h00, 8'h02);
    // Continuous mode picks up a new level without another write
    bus(8'h00, 8'h24, 1'b1);
    repeat (40) @(posedge ref_clk);
    while (sample_enable) @(posedge ref_clk);
    seed = xs(seed);
    pin_level[4] = seed[7:0];
    repeat (40) @(posedge ref_clk);
    rd(8'h00, 8'hA4);
    rd(8'h01, seed[7:0]);
    repeat (40) @(posedge ref_clk);
    rd(8'h00, 8'h24);
    bus(8'h00, 8'h1F, 1'b1);
    repeat (3) @(posedge ref_clk);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
